// ### common/rgc_pkg.sv
// Package of constants and types for the reading gate command block.
package rgc_pkg;
  // ==========================================================
  // Command characters and reply characters.
  localparam logic [7:0] CH_OPEN  = 8'h2B; // '+'
  localparam logic [7:0] CH_CLOSE = 8'h2D; // '-'
  localparam logic [7:0] CH_O     = 8'h4F;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_TWO   = 8'h32;
  localparam logic [7:0] CH_QRY   = 8'h3F;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_IN    = 8'h49; // 'I'
  localparam logic [7:0] CH_PAS   = 8'h50; // 'P'
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_EQ    = 8'h3D;
  localparam logic [7:0] CH_SEMI  = 8'h3B;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_GOOD  = 8'h47; // 'G'
  localparam logic [7:0] CH_FAIL  = 8'h4E; // 'N'
  localparam logic [3:0] QRY_LAST = 4'hC;
  localparam logic [3:0] RES_LAST = 4'h1;
  // ==========================================================
  // Register byte offsets and reset values.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_LIMIT  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ISTAT  = 8'h0C;
  localparam logic [7:0] OFS_IMASK  = 8'h10;
  localparam logic [2:0] CTRL_RST   = 3'h0;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam int CTRL_INV   = 0;
  localparam int CTRL_MODE  = 1;
  localparam int INT_OPEN   = 0;
  localparam int INT_GOOD   = 1;
  localparam int INT_FAIL   = 2;
  // ==========================================================
  // Timing: one timeout tick per millisecond.
  localparam int CLK_KHZ    = 25000;
  localparam int TICK_MS    = 1;
  localparam int TICK_CYC   = CLK_KHZ * TICK_MS;
  // ==========================================================
  // Types.
  typedef enum logic [1:0] {
    PORT_OUT, PORT_IN, PORT_PASSIVE, PORT_RSVD
  } rgc_mode_e;
  typedef enum logic [2:0] {
    P_IDLE, P_O, P_ACT, P_DEACT
  } rgc_parse_e;
  typedef enum logic [1:0] {
    REP_NONE, REP_QRY, REP_RES
  } rgc_rep_e;
  typedef struct packed {
    logic       done;
    logic       hasCode;
    logic       same;
  } rgc_scan_s;
  typedef struct packed {
    logic [7:0] adr;
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [31:0] dat;
  } rgc_wb_s;
endpackage

// ### test/reading_gate_and_output_commands_bench.sv
// Self-checking bench of the reading gate command block.
`timescale 1ns/1ps
module reading_gate_and_output_commands_bench;
  import rgc_pkg::*;
  // ==========================================================
  // Signals.
  logic       core_clk = 1'b0;
  logic       rstn     = 1'b0;
  rgc_wb_s    wbIn     = '0;
  logic       wbAck;
  logic [31:0] wbDatO;
  logic       rxValid  = 1'b0;
  logic [7:0] rxData   = 8'h00;
  logic       txReady;
  logic       txValid;
  logic [7:0] txData;
  rgc_scan_s  scan     = '0;
  logic       decodeEn;
  logic       switchInOne = 1'b0;
  logic       switchOutTwo;
  logic       irq;
  int         n_errors = 0;
  int         samples_checked = 0;
  logic [31:0] rd;
  string      s;
  string      cmd;

  always #20 core_clk = ~core_clk;

  // A short tick keeps the millisecond timeout within a few cycles.
  rgc_gate #(.TICK_CYCLES(10)) i_dut (
    .core_clk(core_clk), .rstn(rstn), .wbIn(wbIn), .wbAck(wbAck),
    .wbDatO(wbDatO), .rxValid(rxValid), .rxData(rxData),
    .txReady(txReady), .txValid(txValid), .txData(txData), .scan(scan),
    .decodeEn(decodeEn), .switchInOne(switchInOne),
    .switchOutTwo(switchOutTwo), .irq(irq)
  );
  rgc_host u_host (
    .core_clk(core_clk), .rstn(rstn), .txValid(txValid),
    .txData(txData), .txReady(txReady)
  );

  // ==========================================================
  // Reporting.
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic hang(input string what);
    n_errors++;
    $display("CHECK FAILED at %0t: no %s", $time, what);
    complete_run();
  endtask

  // ==========================================================
  // Bus, command and scan drivers.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int i;
    i = 0;
    @(posedge core_clk);
    wbIn <= '{a, 1'b1, 1'b1, we, 4'hF, d};
    do begin
      @(posedge core_clk);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    if (i >= 20) hang("ack");
    q = wbDatO;
    wbIn <= '0;
  endtask
  task automatic send(input string c);
    int i;
    // Random junk first: unknown characters must leave the parser idle.
    @(posedge core_clk);
    rxValid <= 1'b1;
    rxData <= 8'h61 + 8'($urandom % 26);
    for (i = 0; i < c.len(); i++) begin
      @(posedge core_clk);
      rxData <= c[i];
    end
    @(posedge core_clk);
    rxValid <= 1'b0;
  endtask
  task automatic pulse(input logic has, input logic same);
    @(posedge core_clk);
    scan <= '{1'b1, has, same};
    @(posedge core_clk);
    scan <= '0;
  endtask
  task automatic gate(input logic v, input int lim);
    int i;
    i = 0;
    @(negedge core_clk);
    while (decodeEn !== v) begin
      @(negedge core_clk);
      i++;
      if (i > lim) hang("gate change");
    end
  endtask
  task automatic reply(input string e);
    int i;
    i = 0;
    while (u_host.got.size() < e.len()) begin
      @(posedge core_clk);
      i++;
      if (i > 400) hang("reply");
    end
    for (i = 0; i < e.len(); i++) begin
      check(u_host.got.pop_front(), e[i]);
    end
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    logic [7:0] ofs[6];
    int m;
    ofs = '{OFS_CTRL, OFS_LIMIT, OFS_STATUS, OFS_ISTAT, OFS_IMASK, 8'h20};
    void'($urandom(89));
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (ofs[k]) begin
      wb(1'b0, ofs[k], '0, rd);
      check(rd, 32'h0000_0000);
    end
    $display("test reset done");

    send("+");
    @(negedge core_clk);
    check(decodeEn, 1'b1);
    repeat (6) @(posedge core_clk);
    check(u_host.got.size(), 0);
    send("-");
    gate(1'b0, 2);
    reply(string'({CH_FAIL, CH_CR}));
    wb(1'b0, OFS_ISTAT, '0, rd);
    check(rd, 32'h0000_0005);
    wb(1'b1, OFS_IMASK, 32'h0000_0004, rd);
    repeat (2) @(negedge core_clk);
    check(irq, 1'b1);
    wb(1'b1, OFS_ISTAT, 32'h0000_0005, rd);
    repeat (2) @(negedge core_clk);
    check(irq, 1'b0);
    $display("test manual gate done");

    wb(1'b1, OFS_LIMIT, 32'h0000_0003, rd);
    send("+");
    pulse(1'b1, 1'b1);
    pulse(1'b1, 1'b1);
    send("+");
    @(negedge core_clk);
    check(decodeEn, 1'b1);
    pulse(1'b1, 1'b1);
    gate(1'b0, 3);
    reply(string'({CH_GOOD, CH_CR}));
    wb(1'b1, OFS_LIMIT, 32'h0000_0200, rd);
    send("+");
    pulse(1'b0, 1'b0);
    @(negedge core_clk);
    check(decodeEn, 1'b1);
    pulse(1'b0, 1'b0);
    gate(1'b0, 3);
    reply(string'({CH_FAIL, CH_CR}));
    $display("test scan counts done");

    wb(1'b1, OFS_LIMIT, 32'h0002_0000, rd);
    send("+");
    repeat (5) @(negedge core_clk);
    check(decodeEn, 1'b1);
    gate(1'b0, 40);
    reply(string'({CH_FAIL, CH_CR}));
    wb(1'b1, OFS_LIMIT, 32'h0000_0000, rd);
    wb(1'b1, OFS_CTRL, 32'h0000_0002, rd);
    send("+");
    repeat (10) @(negedge core_clk);
    check(decodeEn, 1'b1);
    @(posedge core_clk);
    switchInOne <= 1'b1;
    gate(1'b0, 8);
    reply(string'({CH_FAIL, CH_CR}));
    $display("test timeout and input done");

    // Port 1 modes output, input, passive, reserved; inversion only with
    // passive. The reserved mode has to report like an output.
    for (m = 0; m < 4; m++) begin
      wb(1'b1, OFS_CTRL, 32'((m << 1) | (m == 2)), rd);
      case (m)
        1:       cmd = string'({CH_O, CH_A, CH_SP, CH_TWO});
        2:       cmd = string'({CH_O, CH_D, CH_SP, CH_TWO});
        default: cmd = string'({CH_O, CH_A, CH_TWO});
      endcase
      send(cmd);
      repeat (2) @(negedge core_clk);
      check(switchOutTwo, (m != 2) ^ (m == 2));
      wb(1'b0, OFS_STATUS, '0, rd);
      check(rd[1], m != 2);
      send(string'({CH_O, CH_A, CH_QRY}));
      s = string'({CH_O, CH_A, CH_SP, CH_S, CH_ONE, CH_EQ,
                   m == 1 ? CH_IN : (m == 2 ? CH_PAS : CH_ZERO),
                   CH_SEMI, CH_S, CH_TWO, CH_EQ,
                   m == 2 ? CH_ZERO : CH_ONE, CH_CR});
      reply(s);
    end
    $display("test switching output done");

    // A reset in mid-run must close an open gate and clear the output.
    send("+");
    @(negedge core_clk);
    check(decodeEn, 1'b1);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check(decodeEn, 1'b0);
    check(switchOutTwo, 1'b0);
    wb(1'b0, OFS_CTRL, '0, rd);
    check(rd, 32'h0000_0000);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule

// ### test/rgc_host.sv
// Host side model: takes reply characters with random stalls.
`timescale 1ns/1ps
module rgc_host (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Reply characters from the block.
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady
);
  // ==========================================================
  // Received characters, drained by the bench.
  logic [7:0] got[$];

  // Random stalls make the block hold each character until taken.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      txReady <= 1'b0;
    end else begin
      if (txValid && txReady) begin
        got.push_back(txData);
      end
      txReady <= ($urandom % 3) != 0;
    end
  end
endmodule

// ### verilog/rgc_gate.sv
// Reading gate and switching output command interpreter.
//
// Overview of operation
// - Open command opens gate, starts decoding silently.
// - Gate stays open; close command or input.
// - Close gate when equal scans reach count.
// - Close gate when gate timeout expires.
// - Close gate after preset empty scan count.
// - Close command closes gate, emits read result.
// - Manual close without success emits failure result.
// - Activate command port 2 drives output active.
// - Logical state; inversion applied at pin.
// - Query replies port 1 and 2 states.
// - State chars: 0, 1, I, P.
`timescale 1ns/1ps
module rgc_gate
  import rgc_pkg::*;
#(
  parameter int TICK_CYCLES = rgc_pkg::TICK_CYC
) (
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rstn,
  // Wishbone slave.
  input  wire rgc_pkg::rgc_wb_s wbIn,
  output logic                  wbAck,
  output logic [31:0]           wbDatO,
  // Command characters in, reply characters out.
  input  wire logic             rxValid,
  input  wire logic [7:0]       rxData,
  input  wire logic             txReady,
  output logic                  txValid,
  output logic [7:0]            txData,
  // Decoder.
  input  wire rgc_pkg::rgc_scan_s scan,
  output logic                  decodeEn,
  // Pins.
  input  wire logic             switchInOne,
  output logic                  switchOutTwo,
  // Interrupt.
  output logic                  irq
);
  import rgc_pkg::*;

  typedef struct packed {
    logic        gateOpen;
    logic        good;
    rgc_parse_e  pst;
    logic        out2;
    logic        pin2;
    logic [2:0]  ctrl;
    logic [31:0] limit;
    logic [2:0]  iStat;
    logic [2:0]  iMask;
    logic        ack;
    logic [31:0] dat;
    logic        irq;
    logic        txValid;
    logic [7:0]  txData;
    rgc_rep_e    rep;
    logic [3:0]  idx;
    logic [15:0] tick;
    logic [15:0] ms;
    logic [7:0]  eqCnt;
    logic [7:0]  emCnt;
    logic        swPrev;
  } rgc_state_s;

  rgc_state_s st;
  rgc_state_s next_st;
  logic       swIn;

  rgc_sync u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .din      (switchInOne),
    .dout     (swIn)
  );

  // ==========================================================
  // Reply characters.
  function automatic logic [7:0] portChar(rgc_mode_e m, logic v);
    unique case (m)
      PORT_IN:      portChar = CH_IN;
      PORT_PASSIVE: portChar = CH_PAS;
      default:      portChar = v ? CH_ONE : CH_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] qryChar(logic [3:0] i, logic [7:0] a,
                                         logic [7:0] b);
    case (i)
      4'h0:    qryChar = CH_O;
      4'h1:    qryChar = CH_A;
      4'h2:    qryChar = CH_SP;
      4'h3:    qryChar = CH_S;
      4'h4:    qryChar = CH_ONE;
      4'h5:    qryChar = CH_EQ;
      4'h6:    qryChar = a;
      4'h7:    qryChar = CH_SEMI;
      4'h8:    qryChar = CH_S;
      4'h9:    qryChar = CH_TWO;
      4'hA:    qryChar = CH_EQ;
      4'hB:    qryChar = b;
      default: qryChar = CH_CR;
    endcase
  endfunction

  // ==========================================================
  // Next state.
  logic [7:0]  p1Char;
  logic [7:0]  p2Char;
  logic        busy;
  logic        wbReq;
  logic        wrStb;
  logic        cmdOpen;
  logic        cmdClose;
  logic        cmdQry;
  logic        tickHit;
  logic        eqHit;
  logic        emHit;
  logic        toHit;
  logic        swHit;
  logic        closing;
  logic        closeGood;
  logic [2:0]  ev;
  logic [7:0]  eqNext;

  always_comb begin
    next_st  = st;
    p1Char   = portChar(rgc_mode_e'(st.ctrl[CTRL_MODE +: 2]), 1'b0);
    p2Char   = portChar(PORT_OUT, st.out2);
    busy     = st.rep != REP_NONE;
    wbReq    = wbIn.cyc && wbIn.stb && !st.ack;
    wrStb    = wbReq && wbIn.we;
    cmdOpen  = 1'b0;
    cmdClose = 1'b0;
    cmdQry   = 1'b0;
    ev       = 3'h0;

    // Command parser.
    if (rxValid) begin
      next_st.pst = P_IDLE;
      unique case (st.pst)
        P_IDLE: begin
          cmdOpen  = rxData == CH_OPEN;
          cmdClose = rxData == CH_CLOSE;
          if (rxData == CH_O) begin
            next_st.pst = P_O;
          end
        end
        P_O: begin
          if (rxData == CH_A) begin
            next_st.pst = P_ACT;
          end else if (rxData == CH_D) begin
            next_st.pst = P_DEACT;
          end
        end
        P_ACT: begin
          if (rxData == CH_SP) begin
            next_st.pst = P_ACT;
          end else if (rxData == CH_TWO) begin
            next_st.out2 = 1'b1;
          end else if (rxData == CH_QRY) begin
            cmdQry = 1'b1;
          end
        end
        P_DEACT: begin
          if (rxData == CH_SP) begin
            next_st.pst = P_DEACT;
          end else if (rxData == CH_TWO) begin
            next_st.out2 = 1'b0;
          end
        end
        default: next_st.pst = P_IDLE;
      endcase
    end

    // Scan counters, timeout tick and closing conditions.
    tickHit = st.tick >= 16'(TICK_CYCLES - 1);
    eqNext  = (scan.same && st.eqCnt != 8'hFF) ? st.eqCnt + 8'h01 : 8'h01;
    eqHit   = scan.done && scan.hasCode && st.limit[7:0] != 8'h00
              && eqNext >= st.limit[7:0];
    emHit   = scan.done && !scan.hasCode && st.limit[15:8] != 8'h00
              && st.emCnt + 8'h01 >= st.limit[15:8];
    toHit   = tickHit && st.limit[31:16] != 16'h0000
              && st.ms + 16'h0001 >= st.limit[31:16];
    swHit   = rgc_mode_e'(st.ctrl[CTRL_MODE +: 2]) == PORT_IN
              && swIn != st.swPrev;
    next_st.swPrev = swIn;
    closing   = st.gateOpen && (cmdClose || eqHit || emHit || toHit
                                || swHit);
    closeGood = eqHit;

    if (st.gateOpen) begin
      next_st.tick = tickHit ? 16'h0000 : st.tick + 16'h0001;
      if (tickHit) begin
        next_st.ms = st.ms + 16'h0001;
      end
      if (scan.done) begin
        next_st.eqCnt = scan.hasCode ? eqNext : st.eqCnt;
        next_st.emCnt = scan.hasCode ? 8'h00 : st.emCnt + 8'h01;
      end
    end

    if (closing) begin
      next_st.gateOpen = 1'b0;
      next_st.good     = closeGood;
      ev[INT_GOOD]     = closeGood;
      ev[INT_FAIL]     = !closeGood;
    end else if (cmdOpen && !st.gateOpen) begin
      // Reopening an open gate would restart its timeout.
      next_st.gateOpen = 1'b1;
      next_st.good     = 1'b0;
      next_st.tick     = 16'h0000;
      next_st.ms       = 16'h0000;
      next_st.eqCnt    = 8'h00;
      next_st.emCnt    = 8'h00;
      ev[INT_OPEN]     = 1'b1;
    end

    // Reply sequencer; a result outranks a query that meets it.
    if (st.txValid && txReady) begin
      next_st.txValid = 1'b0;
      if ((st.rep == REP_QRY && st.idx == QRY_LAST)
          || (st.rep == REP_RES && st.idx == RES_LAST)) begin
        next_st.rep = REP_NONE;
      end else begin
        next_st.idx = st.idx + 4'h1;
      end
    end
    if (!busy && closing) begin
      next_st.rep = REP_RES;
      next_st.idx = 4'h0;
    end else if (!busy && cmdQry) begin
      next_st.rep = REP_QRY;
      next_st.idx = 4'h0;
    end
    if (next_st.rep != REP_NONE && !next_st.txValid) begin
      next_st.txValid = 1'b1;
      next_st.txData  = next_st.rep == REP_RES
                        ? (next_st.idx == 4'h0
                           ? (next_st.good ? CH_GOOD : CH_FAIL)
                           : CH_CR)
                        : qryChar(next_st.idx, p1Char, p2Char);
    end

    // Wishbone register file.
    next_st.ack = wbReq;
    next_st.dat = 32'h0000_0000;
    if (wbReq) begin
      case (wbIn.adr)
        OFS_CTRL:   next_st.dat = {29'h0, st.ctrl};
        OFS_LIMIT:  next_st.dat = st.limit;
        OFS_STATUS: next_st.dat = {29'h0, st.good, st.out2, st.gateOpen};
        OFS_ISTAT:  next_st.dat = {29'h0, st.iStat};
        OFS_IMASK:  next_st.dat = {29'h0, st.iMask};
        default:    next_st.dat = 32'h0000_0000;
      endcase
    end
    if (wrStb && wbIn.sel[0]) begin
      if (wbIn.adr == OFS_CTRL) begin
        next_st.ctrl = wbIn.dat[2:0];
      end
      if (wbIn.adr == OFS_IMASK) begin
        next_st.iMask = wbIn.dat[2:0];
      end
    end
    if (wrStb && wbIn.adr == OFS_LIMIT) begin
      for (int b = 0; b < 4; b++) begin
        if (wbIn.sel[b]) begin
          next_st.limit[8*b +: 8] = wbIn.dat[8*b +: 8];
        end
      end
    end
    // Hardware set beats a write-one clear in the same cycle.
    if (wrStb && wbIn.sel[0] && wbIn.adr == OFS_ISTAT) begin
      next_st.iStat = st.iStat & ~wbIn.dat[2:0];
    end
    next_st.iStat = next_st.iStat | ev;
    next_st.irq   = |(next_st.iStat & next_st.iMask);
    next_st.pin2  = next_st.out2 ^ next_st.ctrl[CTRL_INV];
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st       <= '0;
      st.pst   <= P_IDLE;
      st.rep   <= REP_NONE;
      st.ctrl  <= CTRL_RST;
      st.limit <= LIMIT_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wbAck        = st.ack;
  assign wbDatO       = st.dat;
  assign txValid      = st.txValid;
  assign txData       = st.txData;
  assign decodeEn     = st.gateOpen;
  assign switchOutTwo = st.pin2;
  assign irq          = st.irq;

  // ==========================================================
  // Assertions.
  property p_open;
    @(posedge core_clk) disable iff (!rstn)
    (rxValid && st.pst == P_IDLE && rxData == CH_OPEN && !closing)
      |=> st.gateOpen;
  endproperty
  a_open: assert property (p_open)
    else $error("gate did not open");

  property p_stay;
    @(posedge core_clk) disable iff (!rstn)
    (st.gateOpen && !closing) |=> st.gateOpen;
  endproperty
  a_stay: assert property (p_stay)
    else $error("gate closed without cause");

  property p_eq;
    @(posedge core_clk) disable iff (!rstn)
    (st.gateOpen && eqHit) |=> (!st.gateOpen && st.good);
  endproperty
  a_eq: assert property (p_eq)
    else $error("equal scans did not close gate");

  property p_to;
    @(posedge core_clk) disable iff (!rstn)
    (st.gateOpen && toHit) |=> !st.gateOpen;
  endproperty
  a_to: assert property (p_to)
    else $error("timeout did not close gate");

  property p_em;
    @(posedge core_clk) disable iff (!rstn)
    (st.gateOpen && emHit) |=> !st.gateOpen;
  endproperty
  a_em: assert property (p_em)
    else $error("empty scans did not close gate");

  property p_res;
    @(posedge core_clk) disable iff (!rstn)
    (closing && !busy) |=> (st.rep == REP_RES && st.txValid);
  endproperty
  a_res: assert property (p_res)
    else $error("no result after close");

  property p_fail;
    @(posedge core_clk) disable iff (!rstn)
    (closing && !busy && !eqHit) |=> (st.txData == CH_FAIL);
  endproperty
  a_fail: assert property (p_fail)
    else $error("manual close did not report failure");

  property p_out2;
    @(posedge core_clk) disable iff (!rstn)
    (rxValid && st.pst == P_ACT && rxData == CH_TWO) |=> st.out2;
  endproperty
  a_out2: assert property (p_out2)
    else $error("output two not activated");

  property p_inv;
    @(posedge core_clk) disable iff (!rstn)
    switchOutTwo == (st.out2 ^ st.ctrl[CTRL_INV]);
  endproperty
  a_inv: assert property (p_inv)
    else $error("pin does not follow logic and inversion");

  property p_qry;
    @(posedge core_clk) disable iff (!rstn)
    (cmdQry && !busy && !closing) |=> (st.txData == CH_O && st.txValid);
  endproperty
  a_qry: assert property (p_qry)
    else $error("query reply did not start");

  property p_sep;
    @(posedge core_clk) disable iff (!rstn)
    (st.rep == REP_QRY && st.idx == 4'h7 && st.txValid)
      |-> st.txData == CH_SEMI;
  endproperty
  a_sep: assert property (p_sep)
    else $error("bad query separator");

  property p_keep;
    @(posedge core_clk) disable iff (!rstn)
    (st.gateOpen && cmdOpen && !tickHit && !closing)
      |=> st.tick == $past(st.tick) + 16'h0001;
  endproperty
  a_keep: assert property (p_keep)
    else $error("reopen restarted the timeout");

  property p_ack;
    @(posedge core_clk) disable iff (!rstn)
    st.ack |=> !st.ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held longer than one cycle");

  c_open: cover property (@(posedge core_clk) disable iff (!rstn)
    st.gateOpen ##[1:50] !st.gateOpen);
  c_good: cover property (@(posedge core_clk) disable iff (!rstn)
    st.gateOpen && eqHit);
  c_qry: cover property (@(posedge core_clk) disable iff (!rstn)
    st.rep == REP_QRY && st.idx == QRY_LAST);
  c_irq: cover property (@(posedge core_clk) disable iff (!rstn)
    irq);
endmodule

// ### verilog/rgc_sync.sv
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module rgc_sync (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic rstn,
  // Level.
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  // The first stage feeds only the second stage.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      dout   <= 1'b0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
